// [core/epic_pkg.sv]
// epic_pkg: register map, field positions, reset values and timing of the pin interrupt unit
package epic_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [4:0] OFS_CTRL    = 5'h00;
  localparam logic [4:0] OFS_STATUS  = 5'h01;
  localparam logic [4:0] OFS_NMICFG  = 5'h02;
  localparam logic [4:0] OFS_NONMASKABLE_FLAG = 5'h03;
  localparam logic [4:0] OFS_EVOEN   = 5'h04;
  localparam logic [4:0] OFS_IENCLR  = 5'h08;
  localparam logic [4:0] OFS_IENSET  = 5'h0C;
  localparam logic [4:0] OFS_FLAGS   = 5'h10;
  localparam logic [4:0] OFS_WAKE    = 5'h14;
  localparam logic [4:0] OFS_CFGLO   = 5'h18;
  localparam logic [4:0] OFS_CFGHI   = 5'h1C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_SOFT_RESET_BIT   = 0;
  localparam int BIT_ENABLE  = 1;
  localparam int BIT_BUSY    = 7;
  localparam int BIT_NONMASKABLE_FLAG = 0;
  localparam int BIT_FILTEN  = 3;
  localparam int CFG_W       = 4;
  localparam int MAX_PINS    = 16;

  // ****************************************
  // sense selections
  // ****************************************
  localparam logic [2:0] SNS_NONE = 3'h0;
  localparam logic [2:0] SNS_RISE = 3'h1;
  localparam logic [2:0] SNS_FALL = 3'h2;
  localparam logic [2:0] SNS_BOTH = 3'h3;
  localparam logic [2:0] SNS_HIGH = 3'h4;
  localparam logic [2:0] SNS_LOW  = 3'h5;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int          SYNC_NS  = 30;
  localparam int          CLK_NS   = 10;
  localparam logic [3:0]  SYNC_CYC = 4'((SYNC_NS + CLK_NS - 1) / CLK_NS);

endpackage : epic_pkg

// [core/epic_unit.sv]
// epic_unit: external pin interrupt unit with register bank, filters, events and wake request
//
// Functional notes
// - each pin has an event output enable bit gating its event
// - a sense match on an event-enabled pin emits that pin's event while the enable is in force
// - per-pin wake enable bit permits or forbids wake-up from that pin
// - wake needs a sense match and the pin's interrupt enable set
// - a synchronized operation raises the busy bit at once, clears when done
// - a synchronized write while busy stalls, is held, and completes unless a newer one replaces it
// - only software reset and enable bits go through synchronization
// - 8, 16 and 32 bit accesses reach any byte or half of a register
// - enable-protected registers ignore writes while the unit is enabled
// - enable is control bit 1; it takes effect after the sync delay
// - enable reads back at once; its write sets busy until done
// - writing one to control bit 0 resets all registers, zero does nothing
// - a software reset write discards every other bit of that access
// - reset bit reads one while running; it and busy clear together
// - filter takes three samples and passes their majority
// - request per pin while its flag and interrupt enable are both set
// - nonmaskable flag clears on writing one and always requests when set
// - sense selects none, rise, fall, both edges, high or low
`timescale 1ns/1ns
`default_nettype none

module epic_unit
  import epic_pkg::*;
#(
  parameter int NUM_PINS = 16
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // register port
  input  wire logic [4:0]          bus_addr,
  input  wire logic [31:0]         bus_wdata,
  input  wire logic [3:0]          bus_be,
  input  wire logic                bus_we,
  input  wire logic                bus_re,
  output logic      [31:0]         bus_rdata,
  output logic                     bus_stall,
  // external pins
  input  wire logic [NUM_PINS-1:0] ext_irq_pin,
  input  wire logic                nmi_pin,
  // requests, events and wake
  output logic      [NUM_PINS-1:0] irq_req,
  output logic                     nmi_irq,
  output logic      [NUM_PINS-1:0] pin_event_out,
  output logic                     wake_req
);

  // ****************************************
  // sizes and checks
  // ****************************************
  localparam int N = NUM_PINS;
  localparam int M = NUM_PINS + 1;

  if (NUM_PINS < 1 || NUM_PINS > MAX_PINS) begin : g_bad_pins
    $error("epic_unit: NUM_PINS must lie between 1 and 16");
  end

  // the countdown is four bits wide, so the sync delay must lie in 1..15 cycles
  if ((SYNC_NS + CLK_NS - 1) / CLK_NS < 1 ||
      (SYNC_NS + CLK_NS - 1) / CLK_NS > 15) begin : g_bad_sync
    $error("epic_unit: sync delay must lie between 1 and 15 cycles");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [M-1:0] s1;       // first synchroniser stage
    logic [M-1:0] s2;       // second synchroniser stage
    logic [M-1:0] h0;       // older filter samples
    logic [M-1:0] h1;
    logic [M-1:0] prev;     // last conditioned level, for edges
    logic         en_rd;    // enable as written
    logic         en_act;   // enable in force
    logic         rst_bit;  // software reset under way
    logic [3:0]   cnt;      // sync delay countdown
    logic         pq_v;     // held control write
    logic [1:0]   pq_d;     // {enable, reset} of held write
    logic [3:0]   nmi_cfg;
    logic         nmi_flag;
    logic [N-1:0] evo_en;
    logic [N-1:0] irq_en;
    logic [N-1:0] flags;
    logic [N-1:0] wake_en;
    logic [63:0]  cfg;
    logic [N-1:0] ev_out;
    logic         wake;
    logic [31:0]  rdata;
  } epic_state_t;

  epic_state_t q_r;
  epic_state_t q_nxt;

  // ****************************************
  // per-pin conditioning and detection
  // ****************************************
  logic [M-1:0] fin;   // filtered or direct level
  logic [M-1:0] hit;   // sense condition met

  // slot N is the nonmaskable pin, configured from its own register
  // sense codes 6 and 7 detect nothing, like no detection
  for (genvar i = 0; i < M; i++) begin : g_pin
    logic [2:0] sns;
    logic       fen;
    logic       maj;
    if (i < N) begin : g_ext
      assign sns = q_r.cfg[i*CFG_W +: 3];
      assign fen = q_r.cfg[i*CFG_W + BIT_FILTEN];
    end else begin : g_nmi
      assign sns = q_r.nmi_cfg[2:0];
      assign fen = q_r.nmi_cfg[BIT_FILTEN];
    end
    // two of three samples win, so one glitch sample never passes
    assign maj = (q_r.s2[i] & q_r.h0[i]) | (q_r.s2[i] & q_r.h1[i])
               | (q_r.h0[i] & q_r.h1[i]);
    assign fin[i] = fen ? maj : q_r.s2[i];
    // level senses keep hitting, so a cleared flag sets again at once
    always_comb begin
      case (sns)
        SNS_NONE: hit[i] = 1'b0;
        SNS_RISE: hit[i] = fin[i] & ~q_r.prev[i];
        SNS_FALL: hit[i] = ~fin[i] & q_r.prev[i];
        SNS_BOTH: hit[i] = fin[i] ^ q_r.prev[i];
        SNS_HIGH: hit[i] = fin[i];
        SNS_LOW:  hit[i] = ~fin[i];
        default:  hit[i] = 1'b0;
      endcase
    end
  end

  // external pins only detect while the unit is enabled
  // so flags, events and wake all stay quiet until the enable takes hold
  logic [N-1:0] det;
  assign det = hit[N-1:0] & {N{q_r.en_act}};

  // ****************************************
  // bus decode
  // ****************************************
  logic [31:0] wm;      // byte lane mask
  logic [31:0] wd;      // masked write data
  logic [2:0]  word;
  logic        rst_wr;
  logic        ctl_wr;
  logic        prot;

  // byte enables give 8, 16 and 32 bit access to every lane
  // a narrow write leaves the other lanes of the register untouched
  assign wm = {{8{bus_be[3]}}, {8{bus_be[2]}},
               {8{bus_be[1]}}, {8{bus_be[0]}}};
  assign wd = bus_wdata & wm;
  assign word = bus_addr[4:2];
  assign rst_wr = bus_we && word == OFS_CTRL[4:2]
                  && wd[BIT_SOFT_RESET_BIT];
  // a control write with lane 0 enabled and no reset bit goes to the sync engine
  assign ctl_wr = bus_we && word == OFS_CTRL[4:2]
                  && bus_be[OFS_CTRL[1:0]] && !wd[BIT_SOFT_RESET_BIT];
  // guarded while enabled or still turning on or off
  // a write lost here is silent; software must disable and wait first
  assign prot = q_r.en_rd | q_r.en_act;

  // ****************************************
  // next state
  // ****************************************
  // one pass computes all next values; later assignments in the pass win,
  // which gives a finished software reset priority over everything else and
  // a pin hit priority over a flag clear
  always_comb begin
    logic       go;
    logic [1:0] gd;
    logic       req;
    logic [1:0] rd;
    logic [N-1:0] clr;
    go  = 1'b0;
    gd  = 2'b00;
    req = rst_wr | ctl_wr;
    rd  = {wd[BIT_ENABLE], rst_wr};
    clr = '0;
    q_nxt = q_r;

    // pin sampling; only the second stage reads the first
    q_nxt.s1   = {nmi_pin, ext_irq_pin};
    q_nxt.s2   = q_r.s1;
    q_nxt.h0   = q_r.s2;
    q_nxt.h1   = q_r.h0;
    q_nxt.prev = fin;

    // plain register writes; a reset write drops the whole access
    if (bus_we && !rst_wr) begin
      case (word)
        OFS_CTRL[4:2]: begin
          if (bus_be[OFS_NMICFG[1:0]]) begin
            q_nxt.nmi_cfg = wd[OFS_NMICFG[1:0]*8 +: 4];
          end
          if (wd[OFS_NONMASKABLE_FLAG[1:0]*8 + BIT_NONMASKABLE_FLAG]) begin
            q_nxt.nmi_flag = 1'b0;
          end
        end
        OFS_EVOEN[4:2]: begin
          if (!prot) begin
            q_nxt.evo_en = (q_r.evo_en & ~wm[N-1:0]) | wd[N-1:0];
          end
        end
        OFS_IENCLR[4:2]: begin
          q_nxt.irq_en = q_r.irq_en & ~wd[N-1:0];
        end
        OFS_IENSET[4:2]: begin
          q_nxt.irq_en = q_r.irq_en | wd[N-1:0];
        end
        OFS_FLAGS[4:2]: begin
          clr = wd[N-1:0];
        end
        OFS_WAKE[4:2]: begin
          if (!prot) begin
            q_nxt.wake_en = (q_r.wake_en & ~wm[N-1:0]) | wd[N-1:0];
          end
        end
        OFS_CFGLO[4:2]: begin
          if (!prot) begin
            q_nxt.cfg[31:0] = (q_r.cfg[31:0] & ~wm) | wd;
          end
        end
        OFS_CFGHI[4:2]: begin
          if (!prot) begin
            q_nxt.cfg[63:32] = (q_r.cfg[63:32] & ~wm) | wd;
          end
        end
        default: begin
          q_nxt.cfg = q_r.cfg;
        end
      endcase
    end

    // a new hit beats a clear in the same cycle
    q_nxt.flags = (q_r.flags & ~clr) | det;
    // the nonmaskable pin detects even while the unit is disabled
    if (hit[N]) begin
      q_nxt.nmi_flag = 1'b1;
    end

    // events and wake follow the detections one cycle later
    q_nxt.ev_out = det & q_r.evo_en;
    q_nxt.wake   = |(det & q_r.wake_en & q_r.irq_en);

    // sync engine: one operation at a time, a later one is held
    // only one write is held; a newer one replaces it, so software
    // that keeps writing while busy sees its last value win
    if (req) begin
      if (q_r.cnt != 4'h0 || q_r.pq_v) begin
        q_nxt.pq_v = 1'b1;
        q_nxt.pq_d = rd;
      end else begin
        go = 1'b1;
        gd = rd;
      end
    end
    if (q_r.cnt == 4'h0 && q_r.pq_v) begin
      go = 1'b1;
      gd = q_r.pq_d;
      if (!req) begin
        q_nxt.pq_v = 1'b0;
      end
    end
    if (q_r.cnt != 4'h0) begin
      q_nxt.cnt = q_r.cnt - 4'h1;
    end
    if (q_r.cnt == 4'h1) begin
      if (q_r.rst_bit) begin
        // all registers back to their initial state
        // this wins over any plain write landing in the same cycle
        q_nxt.rst_bit  = RST_BYTE[BIT_SOFT_RESET_BIT];
        q_nxt.en_rd    = RST_BYTE[BIT_ENABLE];
        q_nxt.en_act   = RST_BYTE[BIT_ENABLE];
        q_nxt.nmi_cfg  = RST_BYTE[3:0];
        q_nxt.nmi_flag = RST_BYTE[BIT_NONMASKABLE_FLAG];
        q_nxt.evo_en   = RST_WORD[N-1:0];
        q_nxt.irq_en   = RST_WORD[N-1:0];
        q_nxt.flags    = RST_WORD[N-1:0];
        q_nxt.wake_en  = RST_WORD[N-1:0];
        q_nxt.cfg      = {RST_WORD, RST_WORD};
        q_nxt.ev_out   = RST_WORD[N-1:0];
        q_nxt.wake     = 1'b0;
      end else begin
        q_nxt.en_act = q_r.en_rd;
      end
    end
    if (go) begin
      q_nxt.cnt = SYNC_CYC;
      if (gd[0]) begin
        q_nxt.rst_bit = 1'b1;
      end else begin
        q_nxt.en_rd = gd[1];
      end
    end

    // read data stand only in the cycle after the strobe
    // address bits 1:0 are ignored on reads: the whole word comes back and
    // the master picks its lanes, so narrow reads need no extra decode
    q_nxt.rdata = '0;
    if (bus_re) begin
      case (word)
        OFS_CTRL[4:2]: begin
          q_nxt.rdata[OFS_CTRL[1:0]*8 + BIT_SOFT_RESET_BIT]  = q_r.rst_bit;
          q_nxt.rdata[OFS_CTRL[1:0]*8 + BIT_ENABLE] = q_r.en_rd;
          q_nxt.rdata[OFS_STATUS[1:0]*8 + BIT_BUSY] =
            q_r.cnt != 4'h0 || q_r.pq_v;
          q_nxt.rdata[OFS_NMICFG[1:0]*8 +: 4] = q_r.nmi_cfg;
          q_nxt.rdata[OFS_NONMASKABLE_FLAG[1:0]*8 + BIT_NONMASKABLE_FLAG] = q_r.nmi_flag;
        end
        OFS_EVOEN[4:2]: begin
          q_nxt.rdata[N-1:0] = q_r.evo_en;
        end
        OFS_IENCLR[4:2], OFS_IENSET[4:2]: begin
          q_nxt.rdata[N-1:0] = q_r.irq_en;
        end
        OFS_FLAGS[4:2]: begin
          q_nxt.rdata[N-1:0] = q_r.flags;
        end
        OFS_WAKE[4:2]: begin
          q_nxt.rdata[N-1:0] = q_r.wake_en;
        end
        OFS_CFGLO[4:2]: begin
          q_nxt.rdata = q_r.cfg[31:0];
        end
        OFS_CFGHI[4:2]: begin
          q_nxt.rdata = q_r.cfg[63:32];
        end
        default: begin
          q_nxt.rdata = '0;
        end
      endcase
      // unused pin groups read as zero
      for (int k = 0; k < 8; k++) begin
        if ((word == OFS_CFGLO[4:2] && k >= N) ||
            (word == OFS_CFGHI[4:2] && k + 8 >= N)) begin
          q_nxt.rdata[k*CFG_W +: CFG_W] = 4'h0;
        end
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // every reset value of this unit is zero
  // pin history settles while disabled, so no false edge at enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // requests are plain gates on registered state, so they drop in the
  // same cycle as a flag clear or an enable clear
  assign irq_req       = q_r.flags & q_r.irq_en;
  assign nmi_irq       = q_r.nmi_flag;
  assign pin_event_out = q_r.ev_out;
  assign wake_req      = q_r.wake;
  assign bus_rdata     = q_r.rdata;
  // the master is not held; this flag shows a control write is queued
  assign bus_stall     = q_r.pq_v;

endmodule : epic_unit

`default_nettype wire

// [testbench/epic_checker.sv]
// epic_checker: port-level timing checks for the pin interrupt unit
`timescale 1ns/1ns
`default_nettype none
module epic_checker #(
  parameter int NUM_PINS = 16
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // register port
  input  wire logic [4:0]          bus_addr,
  input  wire logic [31:0]         bus_wdata,
  input  wire logic [3:0]          bus_be,
  input  wire logic                bus_we,
  input  wire logic                bus_re,
  input  wire logic [31:0]         bus_rdata,
  input  wire logic                bus_stall,
  // requests
  input  wire logic [NUM_PINS-1:0] irq_req,
  input  wire logic                nmi_irq,
  input  wire logic                wake_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire        ctl_wr = bus_we && bus_addr[4:2] == 3'h0 && bus_be[0];
  logic [3:0] q_cnt;
  // quiet window: any sync op may still reshape flags, so hold checks wait it out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) q_cnt <= 4'h0;
    else if (ctl_wr || bus_stall) q_cnt <= 4'h8;
    else if (q_cnt != 4'h0) q_cnt <= q_cnt - 4'h1;
  end
  rdata_idle_a: assert property (!$past(bus_re) |-> bus_rdata == 32'h0)
    else $error("read data outside its slot");
  rdata_rsvd_a: assert property (bus_re && bus_addr[4:2] == 3'h0 |=>
    bus_rdata[14:8] == 7'h00 && bus_rdata[7:2] == 6'h00) else $error("reserved ctrl bits set");
  busy_set_a: assert property (ctl_wr && q_cnt == 4'h0 ##1 bus_re && bus_addr[4:2] == 3'h0
    |=> bus_rdata[15] && bus_rdata[0] == $past(bus_wdata[0], 2)
    && ($past(bus_wdata[0], 2) || bus_rdata[1] == $past(bus_wdata[1], 2)))
    else $error("control readback or busy wrong");
  stall_end_a: assert property (bus_stall |-> ##[1:8] !bus_stall)
    else $error("held write never released");
  stall_cause_a: assert property ($rose(bus_stall) |-> $past(ctl_wr))
    else $error("stall without control write");
  irq_hold_a: assert property (q_cnt == 4'h0 && !bus_we
    |=> (irq_req & $past(irq_req)) == $past(irq_req)) else $error("request dropped");
  nmi_hold_a: assert property (nmi_irq && q_cnt == 4'h0 && !bus_we |=> nmi_irq)
    else $error("nonmaskable request dropped");
  ien_clr_a: assert property (bus_we && bus_addr[4:2] == 3'h2 && bus_be[0]
    |=> (irq_req[7:0] & $past(bus_wdata[7:0])) == 8'h00) else $error("request after disable");
  wake_cause_a: assert property (wake_req && q_cnt == 4'h0 && !$past(bus_we)
    && !$past(bus_we, 2) |-> |irq_req) else $error("wake without enabled request");
endmodule : epic_checker
bind epic_unit epic_checker #(.NUM_PINS(NUM_PINS)) chk_i (
  .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_be(bus_be),
  .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata), .bus_stall(bus_stall),
  .irq_req(irq_req), .nmi_irq(nmi_irq), .wake_req(wake_req));
`default_nettype wire

// [testbench/epic_pins.sv]
// epic_pins: far-side pin driver that moves the pins just after a clock edge
`timescale 1ns/1ns
`default_nettype none
module epic_pins (
  // clock
  input  wire logic        clk,
  // wanted levels
  input  wire logic [15:0] pin_want,
  input  wire logic        nmi_want,
  // pins toward the unit
  output var  logic [15:0] ext_irq_pin,
  output var  logic        nmi_pin
);
  // one edge late; a one-cycle want becomes a one-cycle glitch on the pin
  always_ff @(posedge clk) begin
    ext_irq_pin <= pin_want;
    nmi_pin     <= nmi_want;
  end
endmodule : epic_pins
`default_nettype wire

// [testbench/tb.sv]
// tb: self-checking bench for the pin interrupt unit with a register model
`timescale 1ns/1ns
`default_nettype none
module tb
  import epic_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, bus_we = 1'b0, bus_re = 1'b0, nmi_want = 1'b0;
  logic [4:0]  bus_addr = 5'h00;
  logic [3:0]  bus_be = 4'h0;
  logic [31:0] bus_wdata = 32'h0, seed = 32'hCFEC;
  logic [15:0] pin_want = 16'h0, ext_irq_pin, irq_req, pin_event_out;
  logic [31:0] bus_rdata, mdl [8];
  logic        bus_stall, nmi_irq, wake_req, nmi_pin, en_m = 1'b0, stall_seen = 1'b0;
  int          err_count = 0, cmp_count = 0, ev1 = 0, ev3 = 0;
  always #5 clk = ~clk;
  epic_unit #(.NUM_PINS(16)) DUT (.clk(clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_be(bus_be), .bus_we(bus_we), .bus_re(bus_re),
    .bus_rdata(bus_rdata), .bus_stall(bus_stall), .ext_irq_pin(ext_irq_pin),
    .nmi_pin(nmi_pin), .irq_req(irq_req), .nmi_irq(nmi_irq),
    .pin_event_out(pin_event_out), .wake_req(wake_req));
  epic_pins pins_i (.clk(clk), .pin_want(pin_want), .nmi_want(nmi_want),
    .ext_irq_pin(ext_irq_pin), .nmi_pin(nmi_pin));
  // event pulses on pins 1 and 3 are counted and a held write is noted as they happen
  always @(posedge clk) begin
    if (pin_event_out[1] === 1'b1) ev1++;
    if (pin_event_out[3] === 1'b1) ev3++;
    if (bus_stall === 1'b1) stall_seen = 1'b1;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // write leaves the strobe up so writes can run back to back; idle or rd drops it
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] m;
    int w;
    w = int'(a[4:2]);
    for (int i = 0; i < 4; i++) m[8*i+:8] = {8{b[i]}};
    m = m & ((w > 5) ? 32'hFFFF_FFFF : 32'h0000_FFFF);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_be    <= b;
    bus_we    <= 1'b1;
    bus_re    <= 1'b0;
    @(posedge clk);
    if (w == 2) mdl[3] = mdl[3] & ~(d & m);
    else if (w == 3) mdl[3] = mdl[3] | (d & m);
    else if (w == 4) mdl[4] = mdl[4] & ~(d & m);
    else if (w != 0 && !en_m) mdl[w] = (mdl[w] & ~m) | (d & m);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    bus_addr <= a;
    bus_re   <= 1'b1;
    bus_we   <= 1'b0;
    @(posedge clk);
    bus_re <= 1'b0;
    @(posedge clk);
    d = bus_rdata;
  endtask : rd
  task automatic rdc(input int w);
    logic [31:0] d;
    rd(5'(4 * w), d);
    chk("reg", mdl[(w == 2) ? 3 : w], d);
  endtask : rdc
  task automatic idle(input int n);
    bus_we <= 1'b0;
    bus_re <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic test_done();
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  // a hung handshake ends the run the same way as the main sequence
  initial begin
    #300000;
    err_count++;
    test_done();
  end
  initial begin
    logic [31:0] d;
    logic [31:0] r;
    for (int i = 0; i < 8; i++) mdl[i] = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int w = 0; w < 8; w++) rdc(w);
    for (int i = 0; i < 12; i++) begin
      r = xs();
      wr(5'(4 * (1 + r[10:8] % 7)), xs(), r[3:0]);
    end
    for (int w = 1; w < 8; w++) rdc(w);
    wr(5'h08, 32'hFFFF, 4'hF);
    wr(5'h0C, 32'h00DF, 4'h3);
    wr(5'h04, 32'h0002, 4'hF);
    wr(5'h14, 32'h0010, 4'hF);
    wr(5'h18, 32'h0C54_3210, 4'hF);
    wr(5'h1C, 32'h0000_0076, 4'hF);
    wr(5'h00, 32'h0001_0000, 4'h4);
    wr(5'h00, 32'h2, 4'h1);
    wr(5'h00, 32'h2, 4'h1);
    en_m = 1'b1;
    rd(5'h00, d);
    chk("ctrl", 32'h0001_8002, d);
    idle(12);
    chk("stall", 32'h1, {31'h0, stall_seen});
    rd(5'h00, d);
    chk("ctrl", 32'h0001_0002, d);
    wr(5'h04, 32'hFFFF, 4'hF);
    rdc(1);
    pin_want <= 16'h0040;
    @(posedge clk);
    pin_want <= 16'h0000;
    idle(10);
    mdl[4] = 32'h0020;
    rdc(4);
    chk("wake", 32'h0, {31'h0, wake_req});
    pin_want <= 16'h037F;
    idle(10);
    mdl[4] = 32'h007A;
    rdc(4);
    chk("irq", mdl[4] & mdl[3], {16'h0, irq_req});
    chk("wake", 32'h1, {31'h0, wake_req});
    chk("ev1", 32'h1, 32'(ev1));
    chk("ev3", 32'h0, 32'(ev3));
    wr(5'h10, 32'hFFFF, 4'hF);
    idle(6);
    mdl[4] = 32'h0050;
    rdc(4);
    pin_want <= 16'h0000;
    idle(10);
    mdl[4] = 32'h007C;
    rdc(4);
    chk("ev1", 32'h1, 32'(ev1));
    wr(5'h08, 32'h0004, 4'hF);
    idle(2);
    chk("irq", mdl[4] & mdl[3], {16'h0, irq_req});
    nmi_want <= 1'b1;
    idle(8);
    chk("nmi", 32'h1, {31'h0, nmi_irq});
    wr(5'h00, 32'h0, 4'h8);
    idle(2);
    chk("nmi", 32'h1, {31'h0, nmi_irq});
    wr(5'h00, 32'h0100_0000, 4'h8);
    idle(2);
    chk("nmi", 32'h0, {31'h0, nmi_irq});
    wr(5'h00, 32'h3, 4'h1);
    rd(5'h00, d);
    chk("reset", 32'h0000_8001, d & 32'h0000_8001);
    idle(12);
    for (int i = 0; i < 8; i++) mdl[i] = 32'h0;
    en_m = 1'b0;
    for (int w = 0; w < 8; w++) rdc(w);
    chk("irq", 32'h0, {16'h0, irq_req});
    test_done();
  end
endmodule : tb
`default_nettype wire
